// File: fpam_exec_model.sv
// fpam_exec_model: far-side stand-in giving pipe busy and divider completions
// assumes: same clock and reset as the steering block
`timescale 1ns/1ps
`default_nettype none
module fpam_exec_model #(
    parameter int LAT = fpam_pkg::NORMAL_LAT
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic drain,
    input wire logic [5:0] busy_mask,
    input wire logic [fpam_pkg::DIV_CNT_W-1:0] div_in_flight,
    output logic [5:0] pipe_busy,
    output logic div_done
);
    logic [3:0] cnt_reg;

    // busy pattern as the bench commands it
    assign pipe_busy = busy_mask;

    // one divide finishes every LAT cycles while work waits; drain low stalls
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_reg <= 4'h0;
            div_done <= 1'b0;
        end else begin
            div_done <= 1'b0;
            if (drain && div_in_flight != '0) begin
                if (cnt_reg == 4'(LAT - 1)) begin
                    cnt_reg <= 4'h0;
                    div_done <= 1'b1; // one pulse per finished op
                end else begin
                    cnt_reg <= cnt_reg + 4'h1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// File: fpam_pipe_pick.sv
// fpam_pipe_pick: picks the lowest free permitted pipe for one operation
// assumes: mask and busy come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module fpam_pipe_pick #(
    parameter int NP = 6
) (
    input wire logic [NP-1:0] allowed,
    input wire logic [NP-1:0] busy,
    output logic found,
    output logic [2:0] pipe
);

    // ----------------------------------------------------------------
    // priority pick
    // ----------------------------------------------------------------
    // lowest index wins so steering is deterministic
    always_comb begin
        found = 1'b0;
        pipe = 3'h0;
        for (int i = NP - 1; i >= 0; i--) begin
            if (allowed[i] && !busy[i]) begin
                found = 1'b1;
                pipe = i[2:0];
            end
        end
    end

endmodule
`default_nettype wire

// File: fpam_pkg.sv
// fpam_pkg: shared constants and enumerations for the fp pipe steering block
// assumes: included before every other file of the block
package fpam_pkg;

    // ----------------------------------------------------------------
    // pipe numbering and widths
    // ----------------------------------------------------------------
    localparam int NUM_PIPES = 6;
    localparam int DATAPATH_W = 256;
    localparam int NUM_REGS = 32;
    localparam int REG_IDX_W = 5;
    localparam int DIV_DEPTH = 2;
    localparam int DIV_CNT_W = 2;
    localparam int NORMAL_LAT = 4;
    localparam int DENORM_LAT = 12;
    localparam int LAT_W = 4;

    // pipe masks, bit n set means pipe n permitted
    localparam logic [5:0] MASK_P01 = 6'h03;
    localparam logic [5:0] MASK_P23 = 6'h0c;
    localparam logic [5:0] MASK_P1 = 6'h02;
    localparam logic [5:0] MASK_P0123 = 6'h0f;
    localparam logic [5:0] MASK_P45 = 6'h30;
    localparam logic [5:0] MASK_P12 = 6'h06;
    localparam logic [5:0] MASK_P123 = 6'h0e;
    localparam logic [5:0] MASK_P0 = 6'h01;
    localparam logic [5:0] MASK_NONE = 6'h00;

    // ----------------------------------------------------------------
    // operation classes
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        FPAM_OP_FP_MULTIPLY_UNIT_FMA_CMP = 4'h0,
        FPAM_OP_FP_ADDER_UNIT = 4'h1,
        FPAM_OP_CONVERT = 4'h2,
        FPAM_OP_DIV_SQRT = 4'h3,
        FPAM_OP_FP_MOVE_LOGIC = 4'h4,
        FPAM_OP_STORE_TO_GPR = 4'h5,
        FPAM_OP_INT_ADD_CMP = 4'h6,
        FPAM_OP_INT_ADD_COMPLEX = 4'h7,
        FPAM_OP_PERMUTE = 4'h8,
        FPAM_OP_SIMPLE_SHUFFLE = 4'h9,
        FPAM_OP_INT_SHIFT = 4'ha,
        FPAM_OP_INT_MOVE_LOGIC = 4'hb,
        FPAM_OP_REG_MOVE = 4'hc,
        FPAM_OP_ZERO_IDIOM = 4'hd,
        FPAM_OP_SCALAR_MERGE = 4'he,
        FPAM_OP_OTHER = 4'hf
    } fpam_op_e;

    // divider slot state
    typedef enum logic [1:0] {
        FPAM_DIV_IDLE = 2'h0,
        FPAM_DIV_FAST = 2'h1,
        FPAM_DIV_SLOW = 2'h2
    } fpam_div_e;

endpackage

// File: fpam_steer.sv
// fpam_steer: issue-side pipe steering, divider tracking, denormal replay
// and upper-zero merge tracking for the fp/vector cluster
// assumes: scheduler presents one op per cycle with valid; rename side
// supplies register indices; single core clock
`timescale 1ns/1ps
`default_nettype none
module fpam_steer #(
    parameter int NP = fpam_pkg::NUM_PIPES,
    parameter int NR = fpam_pkg::NUM_REGS,
    parameter int IW = fpam_pkg::REG_IDX_W,
    parameter int DW = fpam_pkg::DATAPATH_W
) (
    input wire logic clk,
    input wire logic arst_n,
    // operation offered by the scheduler
    input wire logic op_valid,
    input wire fpam_pkg::fpam_op_e op_class,
    input wire logic op_is_x87,
    input wire logic op_wide,
    input wire logic [NP-1:0] pipe_busy,
    input wire logic [IW-1:0] op_dst,
    input wire logic [IW-1:0] op_src,
    input wire logic op_upper_nonzero,
    input wire logic op_denormal_seen,
    input wire logic [DW-1:0] op_data,
    // simd fp control and status flags
    input wire logic denormal_inputs_as_zero,
    input wire logic flush_denormal_results,
    input wire logic div_done,
    // answers
    output logic op_ready,
    output logic issue_valid,
    output logic [2:0] issue_pipe,
    output logic issue_second_half,
    output logic issue_zero_latency,
    output logic issue_replay_slow,
    output logic issue_flush_zero,
    output logic [DW-1:0] issue_data,
    output logic [IW-1:0] release_idx,
    output logic release_valid,
    output logic merge_dep_removed,
    output logic [NR-1:0] upper_zero_flags,
    output logic [fpam_pkg::DIV_CNT_W-1:0] div_in_flight
);

    // ----------------------------------------------------------------
    // permitted pipe mask per op class
    // ----------------------------------------------------------------
    function automatic logic [5:0] class_mask(input fpam_pkg::fpam_op_e c);
        unique case (c)
            fpam_pkg::FPAM_OP_FP_MULTIPLY_UNIT_FMA_CMP: class_mask = fpam_pkg::MASK_P01;
            fpam_pkg::FPAM_OP_FP_ADDER_UNIT: class_mask = fpam_pkg::MASK_P23;
            fpam_pkg::FPAM_OP_CONVERT: class_mask = fpam_pkg::MASK_P23;
            fpam_pkg::FPAM_OP_DIV_SQRT: class_mask = fpam_pkg::MASK_P1;
            fpam_pkg::FPAM_OP_FP_MOVE_LOGIC: class_mask = fpam_pkg::MASK_P0123;
            fpam_pkg::FPAM_OP_STORE_TO_GPR: class_mask = fpam_pkg::MASK_P45;
            fpam_pkg::FPAM_OP_INT_ADD_CMP: class_mask = fpam_pkg::MASK_P0123;
            fpam_pkg::FPAM_OP_INT_ADD_COMPLEX: class_mask = fpam_pkg::MASK_P01;
            fpam_pkg::FPAM_OP_PERMUTE: class_mask = fpam_pkg::MASK_P12;
            fpam_pkg::FPAM_OP_SIMPLE_SHUFFLE: class_mask = fpam_pkg::MASK_P123;
            fpam_pkg::FPAM_OP_INT_SHIFT: class_mask = fpam_pkg::MASK_P12;
            fpam_pkg::FPAM_OP_INT_MOVE_LOGIC: class_mask = fpam_pkg::MASK_P0123;
            fpam_pkg::FPAM_OP_REG_MOVE: class_mask = fpam_pkg::MASK_NONE;
            fpam_pkg::FPAM_OP_ZERO_IDIOM: class_mask = fpam_pkg::MASK_NONE;
            fpam_pkg::FPAM_OP_SCALAR_MERGE: class_mask = fpam_pkg::MASK_P23;
            fpam_pkg::FPAM_OP_OTHER: class_mask = fpam_pkg::MASK_P0;
        endcase
    endfunction

    // classes resolved at rename with no execution pipe
    function automatic logic no_pipe(input fpam_pkg::fpam_op_e c);
        no_pipe = (c == fpam_pkg::FPAM_OP_REG_MOVE) || (c == fpam_pkg::FPAM_OP_ZERO_IDIOM);
    endfunction

    // classes that assume normal operands first time round
    function automatic logic denorm_sensitive(input fpam_pkg::fpam_op_e c);
        denorm_sensitive = (c == fpam_pkg::FPAM_OP_FP_MULTIPLY_UNIT_FMA_CMP)
            || (c == fpam_pkg::FPAM_OP_DIV_SQRT);
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [5:0] allowed;
    logic pick_found;
    logic [2:0] pick_pipe;
    logic is_div;
    logic div_full;
    logic half_pending_reg;
    logic [2:0] half_pipe_reg;
    logic take;
    logic flags_both;
    logic flags_any;
    logic slow_needed;
    logic uz_wr_en;
    logic uz_wr_val;
    logic [NR-1:0] uz_flags;
    logic [fpam_pkg::DIV_CNT_W-1:0] div_cnt_reg;
    logic [fpam_pkg::DIV_CNT_W-1:0] div_cnt_next;

    assign allowed = class_mask(op_class);
    assign is_div = (op_class == fpam_pkg::FPAM_OP_DIV_SQRT);
    assign div_full = (div_cnt_reg == fpam_pkg::DIV_CNT_W'(fpam_pkg::DIV_DEPTH));
    assign flags_both = denormal_inputs_as_zero && flush_denormal_results;
    assign flags_any = (denormal_inputs_as_zero || flush_denormal_results) && !op_is_x87;

    fpam_pipe_pick #(
        .NP(NP)
    ) u_pick (
        .allowed(allowed),
        .busy(pipe_busy),
        .found(pick_found),
        .pipe(pick_pipe)
    );

    // ----------------------------------------------------------------
    // acceptance
    // ----------------------------------------------------------------
    // a wide op holds the scheduler for its second 256-bit half
    always_comb begin
        take = 1'b0;
        if (op_valid && !half_pending_reg) begin
            if (no_pipe(op_class)) begin
                take = 1'b1;
            end else if (is_div) begin
                take = pick_found && !div_full;
            end else begin
                take = pick_found;
            end
        end
    end

    // legacy stack ops never get the skip
    assign slow_needed = denorm_sensitive(op_class) && op_denormal_seen
        && !(flags_both && !op_is_x87);

    // ----------------------------------------------------------------
    // divider occupancy, up to two in flight on one pipe
    // ----------------------------------------------------------------
    always_comb begin
        div_cnt_next = div_cnt_reg;
        if (take && is_div && !(div_done && div_cnt_reg != '0)) begin
            div_cnt_next = div_cnt_reg + 1'b1;
        end else if (!(take && is_div) && div_done && div_cnt_reg != '0) begin
            div_cnt_next = div_cnt_reg - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div_cnt_reg <= '0;
        end else begin
            div_cnt_reg <= div_cnt_next;
        end
    end

    // ----------------------------------------------------------------
    // second half of wide ops
    // ----------------------------------------------------------------
    // wider ops run as two passes over the 256-bit path
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            half_pending_reg <= 1'b0;
            half_pipe_reg <= 3'h0;
        end else if (half_pending_reg) begin
            half_pending_reg <= 1'b0;
        end else if (take && op_wide && !no_pipe(op_class)) begin
            half_pending_reg <= 1'b1;
            half_pipe_reg <= pick_pipe;
        end
    end

    // ----------------------------------------------------------------
    // issue outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            issue_valid <= 1'b0;
            issue_pipe <= 3'h0;
            issue_second_half <= 1'b0;
            issue_zero_latency <= 1'b0;
            issue_replay_slow <= 1'b0;
            issue_flush_zero <= 1'b0;
        end else begin
            issue_valid <= half_pending_reg || take;
            issue_second_half <= half_pending_reg;
            issue_pipe <= half_pending_reg ? half_pipe_reg : pick_pipe;
            issue_zero_latency <= take && no_pipe(op_class);
            issue_replay_slow <= take && slow_needed;
            issue_flush_zero <= take && flags_any;
        end
    end

    // denormal data of non-x87 ops replaced by zero while a flush flag is on
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            issue_data <= '0;
        end else if (take) begin
            issue_data <= (flags_any && op_denormal_seen) ? '0 : op_data;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            op_ready <= 1'b0;
        end else begin
            op_ready <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // upper-zero tracking and merge dependency removal
    // ----------------------------------------------------------------
    // zero idiom sets, copy propagates, nonzero upper write clears
    always_comb begin
        uz_wr_en = 1'b0;
        uz_wr_val = 1'b0;
        if (take) begin
            if (op_class == fpam_pkg::FPAM_OP_ZERO_IDIOM) begin
                uz_wr_en = 1'b1;
                uz_wr_val = 1'b1;
            end else if (op_class == fpam_pkg::FPAM_OP_REG_MOVE) begin
                uz_wr_en = 1'b1;
                uz_wr_val = uz_flags[op_src];
            end else if (op_upper_nonzero) begin
                uz_wr_en = 1'b1;
                uz_wr_val = 1'b0;
            end
        end
    end

    fpam_upper_zero #(
        .NR(NR),
        .IW(IW)
    ) u_uz (
        .clk(clk),
        .arst_n(arst_n),
        .wr_en(uz_wr_en),
        .wr_idx(op_dst),
        .wr_val(uz_wr_val),
        .rd_idx(op_dst),
        .rd_val(),
        .all_flags(uz_flags)
    );

    // scalar merging ops skip the wait when upper known zero
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            merge_dep_removed <= 1'b0;
            release_valid <= 1'b0;
            release_idx <= '0;
        end else begin
            merge_dep_removed <= take
                && (op_class == fpam_pkg::FPAM_OP_ZERO_IDIOM
                || (op_class == fpam_pkg::FPAM_OP_SCALAR_MERGE
                && uz_flags[op_dst]));
            release_valid <= take && (op_class == fpam_pkg::FPAM_OP_ZERO_IDIOM);
            release_idx <= op_dst;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            upper_zero_flags <= '0;
            div_in_flight <= '0;
        end else begin
            upper_zero_flags <= uz_flags;
            div_in_flight <= div_cnt_next;
        end
    end

endmodule
`default_nettype wire

// File: fpam_steer_properties.sv
// fpam_steer_properties: port-level timing checks for the fp pipe steering block
// assumes: bound into fpam_steer, one clock, asynchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module fpam_steer_properties #(
    parameter int IW = 5,
    parameter int DW = 256
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire fpam_pkg::fpam_op_e op_class,
    input wire logic op_is_x87,
    input wire logic op_wide,
    input wire logic [IW-1:0] op_dst,
    input wire logic op_denormal_seen,
    input wire logic denormal_inputs_as_zero,
    input wire logic flush_denormal_results,
    input wire logic div_done,
    input wire logic issue_valid,
    input wire logic [2:0] issue_pipe,
    input wire logic issue_second_half,
    input wire logic issue_zero_latency,
    input wire logic issue_replay_slow,
    input wire logic [DW-1:0] issue_data,
    input wire logic [IW-1:0] release_idx,
    input wire logic release_valid,
    input wire logic [fpam_pkg::DIV_CNT_W-1:0] div_in_flight
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    fpam_pkg::fpam_op_e cls_q;
    logic first, div_iss, mul_iss;

    // first pass of an issue and the class that caused it
    assign first = issue_valid && !issue_second_half;
    assign div_iss = first && cls_q == fpam_pkg::FPAM_OP_DIV_SQRT;
    assign mul_iss = first && cls_q == fpam_pkg::FPAM_OP_FP_MULTIPLY_UNIT_FMA_CMP;

    // class offered on the previous edge
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cls_q <= fpam_pkg::FPAM_OP_OTHER;
        end else begin
            cls_q <= op_class;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    AST_MUL_PIPES: assert property (
        mul_iss |-> issue_pipe inside {3'h0, 3'h1}) else $error("multiply off pipes 0-1");
    AST_CONV_PIPES: assert property (
        first && cls_q == fpam_pkg::FPAM_OP_CONVERT |-> issue_pipe inside {3'h2, 3'h3})
        else $error("convert off pipes 2-3");
    AST_DIV_PIPE: assert property (
        div_iss |-> issue_pipe == 3'h1) else $error("divide off pipe 1");
    AST_DIV_CAP: assert property (
        $past(div_in_flight) == 2'h2 && !$past(div_done) |-> !div_iss && div_in_flight == 2'h2)
        else $error("third divide accepted");
    AST_WIDE: assert property (
        first && $past(op_wide) |=> issue_valid && issue_second_half && $stable(issue_pipe))
        else $error("wide op second pass missing");
    AST_REPLAY: assert property (
        mul_iss && $past(op_denormal_seen) |-> issue_replay_slow == ($past(op_is_x87)
        || !($past(denormal_inputs_as_zero) && $past(flush_denormal_results))))
        else $error("denormal replay choice wrong");
    AST_FLUSH: assert property (
        mul_iss && $past(op_denormal_seen) && !$past(op_is_x87)
        && ($past(denormal_inputs_as_zero) || $past(flush_denormal_results))
        |-> issue_data == '0) else $error("denormal not flushed");
    AST_ZLAT: assert property (
        issue_zero_latency |-> cls_q inside {fpam_pkg::FPAM_OP_REG_MOVE,
        fpam_pkg::FPAM_OP_ZERO_IDIOM}) else $error("zero latency on wrong class");
    AST_RELEASE: assert property (
        release_valid |-> cls_q == fpam_pkg::FPAM_OP_ZERO_IDIOM && issue_zero_latency
        && release_idx == $past(op_dst)) else $error("release index wrong");
endmodule

bind fpam_steer fpam_steer_properties #(.IW(IW), .DW(DW)) u_props (
    .clk, .arst_n, .op_class, .op_is_x87, .op_wide, .op_dst, .op_denormal_seen,
    .denormal_inputs_as_zero, .flush_denormal_results, .div_done, .issue_valid,
    .issue_pipe, .issue_second_half, .issue_zero_latency, .issue_replay_slow,
    .issue_data, .release_idx, .release_valid, .div_in_flight
);
`default_nettype wire

// File: fpam_steer_tb_top.sv
// fpam_steer_tb_top: self-checking bench for the fp pipe steering block
// assumes: fpam_pkg, fpam_steer, checker and exec model compiled before it
`timescale 1ns/1ps
`default_nettype none
module fpam_steer_tb_top;
    logic clk, arst_n, op_valid, op_is_x87, op_wide, op_upper_nonzero, op_denormal_seen;
    logic denormal_inputs_as_zero, flush_denormal_results, div_done, drain, op_ready;
    logic issue_valid, issue_second_half, issue_zero_latency, issue_replay_slow;
    logic issue_flush_zero, release_valid, merge_dep_removed;
    logic [2:0] issue_pipe;
    logic [4:0] op_dst, op_src, release_idx;
    logic [5:0] busy_mask, pipe_busy;
    logic [255:0] op_data, issue_data;
    logic [31:0] upper_zero_flags;
    logic [1:0] div_in_flight;
    fpam_pkg::fpam_op_e op_class;
    int error_cnt, checks, cycles;
    fpam_pkg::fpam_op_e cls_t [12] = '{fpam_pkg::FPAM_OP_FP_MULTIPLY_UNIT_FMA_CMP, fpam_pkg::FPAM_OP_FP_ADDER_UNIT,
        fpam_pkg::FPAM_OP_CONVERT, fpam_pkg::FPAM_OP_DIV_SQRT, fpam_pkg::FPAM_OP_FP_MOVE_LOGIC,
        fpam_pkg::FPAM_OP_STORE_TO_GPR, fpam_pkg::FPAM_OP_INT_ADD_CMP,
        fpam_pkg::FPAM_OP_INT_ADD_COMPLEX, fpam_pkg::FPAM_OP_PERMUTE,
        fpam_pkg::FPAM_OP_SIMPLE_SHUFFLE, fpam_pkg::FPAM_OP_INT_SHIFT,
        fpam_pkg::FPAM_OP_INT_MOVE_LOGIC};
    logic [5:0] msk_t [12] = '{6'h03, 6'h0c, 6'h0c, 6'h02, 6'h0f, 6'h30, 6'h0f, 6'h03, 6'h06,
        6'h0e, 6'h06, 6'h0f};

    // ------------------------------------------------------------
    // design, far side and clock
    // ------------------------------------------------------------
    fpam_steer u_dut (.clk, .arst_n, .op_valid, .op_class, .op_is_x87, .op_wide, .pipe_busy,
        .op_dst, .op_src, .op_upper_nonzero, .op_denormal_seen, .op_data,
        .denormal_inputs_as_zero, .flush_denormal_results, .div_done, .op_ready,
        .issue_valid, .issue_pipe, .issue_second_half, .issue_zero_latency,
        .issue_replay_slow, .issue_flush_zero, .issue_data, .release_idx, .release_valid,
        .merge_dep_removed, .upper_zero_flags, .div_in_flight);
    fpam_exec_model u_model (.clk, .arst_n, .drain, .busy_mask, .div_in_flight, .pipe_busy,
        .div_done);

    // free-running core clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // cycle ceiling against a hung sequence
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            error_cnt++;
            summarize();
        end
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic summarize();
        if (error_cnt == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic ok, input string m);
        checks++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask

    task automatic chk_iss(input logic [2:0] p, input logic h, input string m);
        chk(issue_valid === 1'b1 && issue_pipe === p && issue_second_half === h, m);
    endtask

    task automatic step();
        @(posedge clk);
        #2;
    endtask

    // offer an op across one edge; op_valid is left high for back-to-back use
    task automatic offer(input fpam_pkg::fpam_op_e c, input logic [5:0] b);
        op_class = c;
        busy_mask = b;
        op_valid = 1'b1;
        step();
    endtask

    task automatic zop(input fpam_pkg::fpam_op_e c, input logic [4:0] d, input logic nz);
        step();
        op_dst = d;
        op_upper_nonzero = nz;
        offer(c, 6'h00);
        op_valid = 1'b0;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic steer(input fpam_pkg::fpam_op_e c, input logic [5:0] m);
        logic [2:0] lo, hi;
        lo = 3'h0;
        hi = 3'h0;
        for (int i = 5; i >= 0; i--) if (m[i]) lo = 3'(i);
        for (int i = 0; i < 6; i++) if (m[i]) hi = 3'(i);
        step();
        offer(c, 6'h00);
        chk_iss(lo, 1'b0, "lowest free pipe");
        offer(c, m & ~(6'h01 << hi));
        chk_iss(hi, 1'b0, "last free pipe");
        busy_mask = m;
        repeat (6) begin
            step();
            chk(issue_valid === 1'b0, "taken with all pipes busy");
        end
        busy_mask = ~m;
        step();
        op_valid = 1'b0;
        chk_iss(lo, 1'b0, "pipe after stall");
    endtask

    task automatic div_cap();
        int n;
        drain = 1'b0;
        offer(fpam_pkg::FPAM_OP_DIV_SQRT, 6'h00);
        offer(fpam_pkg::FPAM_OP_DIV_SQRT, 6'h00);
        chk(div_in_flight === 2'h2, "two divides not in flight");
        repeat (2) begin
            step();
            chk(issue_valid === 1'b0 && div_in_flight === 2'h2, "third divide");
        end
        drain = 1'b1;
        n = 0;
        while (issue_valid !== 1'b1 && n < 30) begin
            step();
            n++;
        end
        op_valid = 1'b0;
        chk_iss(3'h1, 1'b0, "divide after drain");
    endtask

    task automatic wide_pair();
        step();
        op_wide = 1'b1;
        offer(fpam_pkg::FPAM_OP_FP_ADDER_UNIT, 6'h00);
        op_wide = 1'b0;
        op_class = fpam_pkg::FPAM_OP_FP_MULTIPLY_UNIT_FMA_CMP;
        chk_iss(3'h2, 1'b0, "wide first pass");
        step();
        chk_iss(3'h2, 1'b1, "wide second pass");
        step();
        op_valid = 1'b0;
        chk_iss(3'h0, 1'b0, "op after wide");
    endtask

    task automatic denorm();
        logic [3:0] v;
        logic slow_x;
        step();
        for (int i = 0; i < 16; i++) begin
            v = 4'(i);
            {op_denormal_seen, op_is_x87, denormal_inputs_as_zero, flush_denormal_results} = v;
            op_data = {8{v, 28'h5a5a5a5}};
            slow_x = v[3] && (v[2] || !(v[1] && v[0]));
            offer(fpam_pkg::FPAM_OP_FP_MULTIPLY_UNIT_FMA_CMP, 6'h00);
            chk(issue_replay_slow === slow_x, "replay");
            chk(issue_flush_zero === (!v[2] && |v[1:0]), "flush flag");
            chk(issue_data === ((v[3] && !v[2] && |v[1:0]) ? '0 : op_data), "data");
        end
        op_valid = 1'b0;
        {op_denormal_seen, op_is_x87, denormal_inputs_as_zero, flush_denormal_results} = 4'h0;
    endtask

    task automatic merge();
        zop(fpam_pkg::FPAM_OP_ZERO_IDIOM, 5'h05, 1'b0);
        chk(issue_zero_latency === 1'b1 && release_valid === 1'b1 && release_idx === 5'h05
            && merge_dep_removed === 1'b1, "zeroing idiom");
        op_src = 5'h05;
        zop(fpam_pkg::FPAM_OP_REG_MOVE, 5'h09, 1'b0);
        chk(issue_zero_latency === 1'b1, "register move latency");
        repeat (2) step();
        chk(upper_zero_flags[5] & upper_zero_flags[9], "flag copy");
        zop(fpam_pkg::FPAM_OP_SCALAR_MERGE, 5'h09, 1'b0);
        chk(merge_dep_removed === 1'b1, "merge wait kept");
        zop(fpam_pkg::FPAM_OP_INT_MOVE_LOGIC, 5'h09, 1'b1);
        repeat (2) step();
        chk({upper_zero_flags[9], upper_zero_flags[5]} === 2'h1, "flag clear");
        zop(fpam_pkg::FPAM_OP_SCALAR_MERGE, 5'h09, 1'b0);
        chk(merge_dep_removed === 1'b0, "merge wait dropped");
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        error_cnt = 0;
        checks = 0;
        cycles = 0;
        arst_n = 1'b0;
        op_valid = 1'b0;
        op_class = fpam_pkg::FPAM_OP_OTHER;
        {op_is_x87, op_wide, op_upper_nonzero, op_denormal_seen} = 4'h0;
        {denormal_inputs_as_zero, flush_denormal_results, drain} = 3'h1;
        {op_dst, op_src, busy_mask} = 16'h0000;
        op_data = '0;
        repeat (4) @(posedge clk);
        #2 arst_n = 1'b1;
        step();
        chk(op_ready === 1'b1 && upper_zero_flags === 32'h0, "state after reset");
        div_cap();
        for (int i = 0; i < 12; i++) begin
            if (i < 5) steer(cls_t[i], msk_t[i]);
            else steer(cls_t[i], msk_t[i]);
        end
        wide_pair();
        denorm();
        merge();
        summarize();
    end
endmodule
`default_nettype wire

// File: fpam_upper_zero.sv
// fpam_upper_zero: per-register flags marking the upper portion known zero
// assumes: one write port per cycle from the rename side, same clock
`timescale 1ns/1ps
`default_nettype none
module fpam_upper_zero #(
    parameter int NR = 32,
    parameter int IW = 5
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic wr_en,
    input wire logic [IW-1:0] wr_idx,
    input wire logic wr_val,
    input wire logic [IW-1:0] rd_idx,
    output logic rd_val,
    output logic [NR-1:0] all_flags
);

    logic [NR-1:0] flag_reg;

    // ----------------------------------------------------------------
    // flag storage
    // ----------------------------------------------------------------
    // all flags start cleared: upper bits not known zero
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            flag_reg <= '0;
        end else if (wr_en) begin
            flag_reg[wr_idx] <= wr_val;
        end
    end

    // registered read port
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_val <= 1'b0;
        end else begin
            rd_val <= flag_reg[rd_idx];
        end
    end

    assign all_flags = flag_reg;

endmodule
`default_nettype wire
